// *** inc/pmcc_pkg.sv ***
// Constants and types of the power-mode clock controller
package pmcc_pkg;
    // ==========================================================
    // Timing
    localparam int SYS_CLK_KHZ = 50000;
    localparam int MCLK_SYS = 8;
    localparam int PCLK_MULT = 4;
    localparam int ENTRY_EXTRA_MCLK = 4;
    localparam int WAKE_MAX_MCLK = 4;
    localparam int LOCK_EXTRA_MCLK = 16;
    localparam int PLL_LOCK_MS = 8;
    localparam int PLL_LOCK_CYC = PLL_LOCK_MS * SYS_CLK_KHZ;
    localparam int LOCK_EXTRA_CYC = LOCK_EXTRA_MCLK * MCLK_SYS;
    localparam int WAKE_MAX_CYC = WAKE_MAX_MCLK * MCLK_SYS;
    localparam int ENTRY_MAX_CYC = ENTRY_EXTRA_MCLK * MCLK_SYS;
    // ==========================================================
    // Phase taps of the master phase counter
    localparam logic [2:0] PH_MCLK_EDGE = 3'h3;
    localparam logic [2:0] PH_FAST_EDGE = 3'h1;
    localparam logic [2:0] PH_MASK_MCLK = 3'h3;
    localparam logic [2:0] PH_MASK_FAST = 3'h1;
    // ==========================================================
    // Mode codes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_STBY = 2'h1;
    localparam logic [1:0] MODE_SUSP = 2'h2;
    localparam logic [1:0] MODE_HIBR = 2'h3;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [4:0] hw_int;
        logic timer_int;
        logic nmi;
        logic soft_reset;
    } pmcc_wake_t;
    typedef enum logic [5:0] {
        ST_LOCK = 6'b00_0001,
        ST_FULL = 6'b00_0010,
        ST_DRAIN = 6'b00_0100,
        ST_STBY = 6'b00_1000,
        ST_SUSP = 6'b01_0000,
        ST_HIBR = 6'b10_0000
    } pmcc_state_t;
endpackage

// *** design/pmcc_top.sv ***
// Power-mode sequencer and clock generator
`timescale 1ns/1ns
module pmcc_top #(
    parameter int P_LOCK_CYC = pmcc_pkg::PLL_LOCK_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_link_clk,
    input wire logic i_bus_active,
    input wire logic i_mode_req,
    input wire logic [1:0] i_mode_sel,
    input wire pmcc_pkg::pmcc_wake_t i_wake,
    input wire logic i_sysif_divisor_select,
    output logic o_pipeline_clock,
    output logic o_ref_clock_out,
    output logic o_sysif_clock,
    output logic o_transmit_ref_clock,
    output logic o_pll_on,
    output logic o_timer_clock_on,
    output logic o_pipe_halt,
    output logic o_bus_halt,
    output logic [1:0] o_mode
);
    import pmcc_pkg::*;

    localparam int CW = $clog2(P_LOCK_CYC + LOCK_EXTRA_CYC + 1);
    localparam logic [CW-1:0] LOCK_END =
        CW'(P_LOCK_CYC + LOCK_EXTRA_CYC - 1);

    if (P_LOCK_CYC < 1) begin : g_lock_chk
        $error("P_LOCK_CYC must be at least one cycle");
    end

    // ==========================================================
    // Link domain: bus activity and bus halt
    logic bus_busy_lk_r;
    logic halt_s1_r;
    logic halt_s2_r;
    logic susp_req_r;

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_busy_lk_r <= 1'b0;
        end else begin
            bus_busy_lk_r <= i_bus_active;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            halt_s1_r <= 1'b0;
            halt_s2_r <= 1'b0;
        end else begin
            halt_s1_r <= susp_req_r;
            halt_s2_r <= halt_s1_r;
        end
    end
    assign o_bus_halt = halt_s2_r;

    // ==========================================================
    // Synchronisers into the system domain
    logic busy_s1_r;
    logic busy_s2_r;
    pmcc_wake_t wake_s1_r;
    pmcc_wake_t wake_s2_r;
    logic dsel_s1_r;
    logic dsel_s2_r;
    logic wake_any;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_s1_r <= 1'b1;
            busy_s2_r <= 1'b1;
            wake_s1_r <= '0;
            wake_s2_r <= '0;
        end else begin
            busy_s1_r <= bus_busy_lk_r;
            busy_s2_r <= busy_s1_r;
            wake_s1_r <= i_wake;
            wake_s2_r <= wake_s1_r;
        end
    end
    // no reset, so strap is settled at release
    always_ff @(posedge i_sys_clk) begin
        dsel_s1_r <= i_sysif_divisor_select;
        dsel_s2_r <= dsel_s1_r;
    end
    assign wake_any = |wake_s2_r;

    // ==========================================================
    // Divisor selection, caught once after cold reset
    logic div_fast_r;
    logic cap_done_r;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_fast_r <= 1'b0;
            cap_done_r <= 1'b0;
        end else if (!cap_done_r) begin
            div_fast_r <= dsel_s2_r;
            cap_done_r <= 1'b1;
        end
    end

    // ==========================================================
    // Mode sequencer
    pmcc_state_t state_r;
    pmcc_state_t state_nxt;
    logic [1:0] target_r;
    logic [CW-1:0] lock_cnt_r;
    logic lp_state;

    assign lp_state = (state_r == ST_STBY) || (state_r == ST_SUSP) ||
                      (state_r == ST_HIBR);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_LOCK: begin
                if (lock_cnt_r == LOCK_END) begin
                    state_nxt = ST_FULL;
                end
            end
            ST_FULL: begin
                if (i_mode_req && (i_mode_sel != MODE_FULL)) begin
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!busy_s2_r) begin
                    case (target_r)
                        MODE_STBY: state_nxt = ST_STBY;
                        MODE_SUSP: state_nxt = ST_SUSP;
                        default: state_nxt = ST_HIBR;
                    endcase
                end
            end
            ST_STBY, ST_SUSP: begin
                if (wake_any) begin
                    state_nxt = ST_FULL;
                end
            end
            ST_HIBR: state_nxt = ST_HIBR;
            default: state_nxt = ST_LOCK;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= ST_LOCK;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            target_r <= MODE_FULL;
        end else if (state_r == ST_FULL && i_mode_req) begin
            target_r <= i_mode_sel;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_cnt_r <= '0;
        end else if (state_r == ST_LOCK) begin
            lock_cnt_r <= lock_cnt_r + CW'(1);
        end
    end

    // ==========================================================
    // Clock generation
    logic [2:0] ph_r;
    logic run_pipe;
    logic run_xmit;
    logic run_ref;
    logic fast_edge;
    logic mclk_edge;

    // gating, held high while off or locking
    assign run_ref = (state_r != ST_LOCK) && (state_r != ST_HIBR);
    assign run_xmit = run_ref && (state_r != ST_SUSP);
    assign run_pipe = (state_r == ST_FULL) || (state_r == ST_DRAIN);
    assign mclk_edge = (ph_r & PH_MASK_MCLK) == PH_MCLK_EDGE;
    assign fast_edge = (ph_r & PH_MASK_FAST) == PH_FAST_EDGE;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ph_r <= '0;
        end else begin
            ph_r <= ph_r + 3'h1;
        end
    end

    // pipeline clock, four per master period
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pipeline_clock <= 1'b1;
        end else if (!run_pipe) begin
            o_pipeline_clock <= 1'b1;
        end else begin
            o_pipeline_clock <= ~o_pipeline_clock;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ref_clock_out <= 1'b1;
        end else if (!run_ref) begin
            o_ref_clock_out <= 1'b1;
        end else if (mclk_edge) begin
            o_ref_clock_out <= ~o_ref_clock_out;
        end
    end

    logic sif_edge;
    assign sif_edge = div_fast_r ? fast_edge : mclk_edge;

    // Sysif is internal and stops with the pipeline
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sysif_clock <= 1'b1;
        end else if (!run_pipe) begin
            o_sysif_clock <= 1'b1;
        end else if (sif_edge) begin
            o_sysif_clock <= ~o_sysif_clock;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_transmit_ref_clock <= 1'b1;
        end else if (!run_xmit) begin
            o_transmit_ref_clock <= 1'b1;
        end else if (sif_edge) begin
            o_transmit_ref_clock <= ~o_transmit_ref_clock;
        end
    end

    // ==========================================================
    // Status outputs
    // mode-dependent enables
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pll_on <= 1'b1;
            o_timer_clock_on <= 1'b0;
            o_pipe_halt <= 1'b1;
            susp_req_r <= 1'b0;
            o_mode <= MODE_FULL;
        end else begin
            o_pll_on <= state_nxt != ST_HIBR;
            o_timer_clock_on <= (state_nxt != ST_HIBR) &&
                                (state_nxt != ST_LOCK);
            o_pipe_halt <= !((state_nxt == ST_FULL) ||
                             (state_nxt == ST_DRAIN));
            susp_req_r <= state_nxt == ST_SUSP;
            case (state_nxt)
                ST_STBY: o_mode <= MODE_STBY;
                ST_SUSP: o_mode <= MODE_SUSP;
                ST_HIBR: o_mode <= MODE_HIBR;
                default: o_mode <= MODE_FULL;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    a_hib_no_exit: assert property (
        state_r == ST_HIBR |=> state_r == ST_HIBR)
        else $error("Left hibernate without cold reset");

    a_lp_no_hop: assert property (
        lp_state ##1 lp_state |-> state_r == $past(state_r))
        else $error("Direct hop between low-power modes");

    a_entry_by_req: assert property (
        $rose(state_r == ST_DRAIN) |-> $past(i_mode_req))
        else $error("Low-power entry without request");

    a_entry_time: assert property (
        state_r == ST_DRAIN && !busy_s2_r |=> lp_state)
        else $error("Entry slower than bus idle bound");

    a_wake_time: assert property (
        (state_r == ST_STBY || state_r == ST_SUSP) && wake_any
        |=> state_r == ST_FULL ##1 !o_pipe_halt)
        else $error("Wake not completed in time");

    a_pclk_toggle: assert property (
        run_pipe && $past(run_pipe)
        |-> o_pipeline_clock != $past(o_pipeline_clock))
        else $error("Pipeline clock not toggling in Fullspeed");

    a_stby_clocks: assert property (
        state_r == ST_STBY ##1 state_r == ST_STBY
        |-> o_pipeline_clock && o_pll_on && o_timer_clock_on)
        else $error("Standby clock state wrong");

    a_susp_xmit: assert property (
        state_r == ST_SUSP ##1 state_r == ST_SUSP
        |-> o_transmit_ref_clock && o_pipeline_clock)
        else $error("Transmit clock running in suspend");

    a_hib_clocks: assert property (
        state_r == ST_HIBR ##1 state_r == ST_HIBR
        |-> o_ref_clock_out && o_transmit_ref_clock &&
            o_sysif_clock && !o_pll_on && !o_timer_clock_on)
        else $error("Clock running in hibernate");

    a_div_hold: assert property (
        cap_done_r && $past(cap_done_r) |-> $stable(div_fast_r))
        else $error("Divisor select changed after capture");

endmodule

// *** testbench/pmcc_bus_agent.sv ***
// Bus agent model that keeps the address/data bus busy in bursts
`timescale 1ns/1ns
module pmcc_bus_agent (
    input wire logic i_link_clk,
    input wire logic i_resetn,
    input wire logic i_go,
    input wire logic [7:0] i_busy_len,
    output logic o_bus_active
);
    logic go_r;
    logic [7:0] cnt_r;
    // ==========================================================
    // Burst engine
    // Burst starts on a rising go so a held level cannot restart it
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            go_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            go_r <= i_go;
            if (i_go && !go_r) begin
                cnt_r <= i_busy_len;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
    assign o_bus_active = cnt_r != 8'h00;
endmodule

// *** testbench/test_power_mode_clock_controller.sv ***
// Self-checking bench for the power-mode clock controller
`timescale 1ns/1ns
module test_power_mode_clock_controller;
    import pmcc_pkg::*;
    // ==========================================================
    // Setup
    // Short lock wait keeps each cold reset near 150 cycles
    localparam int LOCK = 20;
    localparam int REC = LOCK + LOCK_EXTRA_CYC;
    typedef struct {
        logic [1:0] sel;
        pmcc_wake_t wk;
        int pc;
        int tx;
        int rf;
        logic [3:0] lv;
    } pmcc_row_t;
    // Levels: pll, timer clock on, bus halt, pipe halt
    pmcc_row_t rows [6] = '{
        '{MODE_STBY, 8'h08, 0, 8, 4, 4'hd},
        '{MODE_STBY, 8'h04, 0, 8, 4, 4'hd},
        '{MODE_SUSP, 8'h02, 0, 0, 4, 4'hf},
        '{MODE_SUSP, 8'h01, 0, 0, 4, 4'hf},
        '{MODE_STBY, 8'h80, 0, 8, 4, 4'hd},
        '{MODE_HIBR, 8'h02, 0, 0, 0, 4'h1}};
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    logic mode_req = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    pmcc_wake_t wake = '0;
    logic div_sel = 1'b1;
    logic go = 1'b0;
    logic [7:0] busy_len = 8'h03;
    logic bus_active;
    logic pc, rf, si, tx, pll, tmr, ph, bh;
    logic [1:0] mode;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t_pc, t_si, t_tx, t_rf, n;
    initial begin
        forever #10 clk = ~clk;
    end
    // Link clock offset so its edges never line up with the system clock
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    pmcc_top #(.P_LOCK_CYC(LOCK)) dut (.i_sys_clk(clk), .i_resetn(resetn),
        .i_link_clk(link_clk), .i_bus_active(bus_active),
        .i_mode_req(mode_req), .i_mode_sel(mode_sel), .i_wake(wake),
        .i_sysif_divisor_select(div_sel), .o_pipeline_clock(pc),
        .o_ref_clock_out(rf), .o_sysif_clock(si),
        .o_transmit_ref_clock(tx), .o_pll_on(pll),
        .o_timer_clock_on(tmr), .o_pipe_halt(ph), .o_bus_halt(bh),
        .o_mode(mode));
    pmcc_bus_agent agent (.i_link_clk(link_clk), .i_resetn(resetn),
        .i_go(go), .i_busy_len(busy_len), .o_bus_active(bus_active));
    // ==========================================================
    // Tasks
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic measure();
        logic [3:0] p;
        t_pc = 0;
        t_si = 0;
        t_tx = 0;
        t_rf = 0;
        @(negedge clk);
        p = {pc, si, tx, rf};
        repeat (16) begin
            @(negedge clk);
            t_pc += int'(pc != p[3]);
            t_si += int'(si != p[2]);
            t_tx += int'(tx != p[1]);
            t_rf += int'(rf != p[0]);
            p = {pc, si, tx, rf};
        end
    endtask
    // Counts only cycles with the bus idle, the start of the entry budget
    task automatic wait_mode(input logic [1:0] m, output int c);
        int k;
        c = 0;
        k = 0;
        while ((mode !== m || ph !== (m != MODE_FULL)) && k < 64) begin
            @(negedge clk);
            k++;
            c += int'(bus_active === 1'b0);
        end
    endtask
    task automatic request(input logic [1:0] s);
        @(posedge clk);
        mode_req <= 1'b1;
        mode_sel <= s;
        @(posedge clk);
        mode_req <= 1'b0;
    endtask
    task automatic enter(input logic [1:0] s, output int c);
        int k;
        @(posedge clk);
        go <= 1'b1;
        k = 0;
        while (bus_active !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        go <= 1'b0;
        // Let the busy level cross into the system domain first
        repeat (6) @(negedge clk);
        request(s);
        @(negedge clk);
        chk("drain waits bus", 3'h0, {mode, ph});
        wait_mode(s, c);
    endtask
    task automatic reset(input logic d);
        int c;
        @(posedge clk);
        resetn <= 1'b0;
        div_sel <= d;
        // Held past two link edges as well
        repeat (9) @(negedge clk);
        chk("reset outputs", 10'h3e8,
            {pc, rf, si, tx, pll, tmr, ph, bh, mode});
        @(posedge clk);
        resetn <= 1'b1;
        c = 0;
        while (ph !== 1'b0 && c < 400) begin
            @(negedge clk);
            c++;
        end
        chk("recovery bound", 1, c <= REC + MCLK_SYS);
        chk("lock wait", 1, c >= LOCK);
        chk("mode after reset", MODE_FULL, mode);
        measure();
        chk("pipeline toggles", 16, t_pc);
        chk("ref toggles", 4, t_rf);
        chk("sysif toggles", d ? 8 : 4, t_si);
        chk("transmit toggles", d ? 8 : 4, t_tx);
        chk("pll timer on", 2'h3, {pll, tmr});
        $display("Test reset done");
    endtask
    // ==========================================================
    // Sequence
    initial begin
        reset(1'b1);
        request(2'h0);
        repeat (20) @(negedge clk);
        chk("null request", 2'h0, {mode, ph});
        foreach (rows[i]) begin
            enter(rows[i].sel, n);
            chk("entry idle cycles", 1, n <= ENTRY_MAX_CYC);
            chk("mode entered", rows[i].sel, mode);
            measure();
            chk("pipeline stop", rows[i].pc, t_pc);
            chk("sysif stop", 0, t_si);
            chk("transmit", rows[i].tx, t_tx);
            chk("ref", rows[i].rf, t_rf);
            chk("stopped level", 2'h3, {pc, si});
            if (rows[i].rf == 0) begin
                chk("all held high", 2'h3, {tx, rf});
            end
            chk("levels", rows[i].lv, {pll, tmr, bh, ph});
            request(rows[i].sel == MODE_SUSP ? MODE_STBY : MODE_SUSP);
            repeat (20) @(negedge clk);
            chk("no lp hop", rows[i].sel, mode);
            @(posedge clk);
            wake <= rows[i].wk;
            wait_mode(MODE_FULL, n);
            if (rows[i].sel == MODE_HIBR) begin
                chk("hibernate holds", MODE_HIBR, mode);
                @(posedge clk);
                wake <= '0;
                reset(1'b1);
            end else begin
                chk("wake cycles", 1, n <= WAKE_MAX_CYC);
                chk("awake", 3'h0, {mode, ph});
                @(posedge clk);
                wake <= '0;
            end
            $display("Test row %0d done", i);
        end
        // Second request during drain must be dropped
        busy_len <= 8'h06;
        @(posedge clk);
        go <= 1'b1;
        repeat (12) @(negedge clk);
        go <= 1'b0;
        request(MODE_STBY);
        request(MODE_HIBR);
        wait_mode(MODE_STBY, n);
        repeat (30) @(negedge clk);
        chk("drain refusal", MODE_STBY, mode);
        @(posedge clk);
        wake <= 8'h20;
        wait_mode(MODE_FULL, n);
        chk("wake int2", 1, n <= WAKE_MAX_CYC);
        @(posedge clk);
        wake <= '0;
        $display("Test drain done");
        reset(1'b0);
        enter(MODE_SUSP, n);
        reset(1'b1);
        end_sim();
    end
endmodule
